// *** verilog/ulb_phy_end.sv ***
/*
  Phy end: makes the interface clock, owns direction and next.
  Assumes link keeps its side of stop, idle zero and release.
*/
`timescale 1ns/10ps
module ulb_phy_end (
  input wire logic clk_in,
  input wire logic rst_in,
  ulb_bus_if.phy bus,
  input wire logic suspend_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  input wire logic stat_req_in,
  input wire logic [7:0] stat_in,
  input wire logic [7:0] reg_rd_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] serial_tx_in,
  output logic rx_take_out,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_valid_out,
  output logic tx_end_out,
  output logic [2:0] mode_out,
  output logic aborted_out
);
  typedef enum {ST_PWRUP, ST_IDLE, ST_TXRX, ST_TURN_UP, ST_RX, ST_STAT, ST_RDATA, ST_TURN_DN, ST_LOWPWR} ulb_phy_e;
  ulb_phy_e state;
  logic [1:0] div;
  logic clk_lvl;
  logic clk_rise;
  logic [2:0] cs_s;
  logic [2:0] cs_r;
  logic cs_n;
  logic stp_q;
  logic [7:0] data_m;
  logic nxt_p;
  logic rx_done;
  logic [7:0] data_q;
  logic rd_pend;
  logic stat_pend;
  logic dir;
  logic nxt;
  logic [7:0] dout;
  logic doe;

  //////////////////////////////////////////////////////////////////////////////
  // interface clock from divider
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div <= 2'h0;
      clk_lvl <= 1'b0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h1) clk_lvl <= 1'b1;
      if (div == 2'h3) clk_lvl <= 1'b0;
    end
  end
  assign clk_rise = (div == 2'h1);
  assign bus.link_clk = clk_lvl;

  //////////////////////////////////////////////////////////////////////////////
  // inputs through two flops
  ulb_edge_sync #(.W(3)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({bus.chip_sel_n, bus.stp, 1'b0}),
    .sync_out(cs_s),
    .rise_out(cs_r)
  );
  assign cs_n = cs_s[2];
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_m <= ulb_pkg::IDLE_BYTE;
      data_q <= ulb_pkg::IDLE_BYTE;
    end else begin
      data_m <= bus.data;
      data_q <= data_m;
    end
  end
  assign stp_q = cs_s[1] & ~cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // bus state machine
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= ST_PWRUP;
      mode_out <= ulb_pkg::MODE_SYNC;
      dir <= 1'b1;
      nxt <= 1'b0;
      rd_pend <= 1'b0;
      stat_pend <= 1'b0;
      tx_byte_out <= ulb_pkg::IDLE_BYTE;
      tx_byte_valid_out <= 1'b0;
      tx_end_out <= 1'b0;
      rx_take_out <= 1'b0;
      aborted_out <= 1'b0;
      dout <= ulb_pkg::IDLE_BYTE;
      doe <= 1'b0;
      nxt_p <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      tx_byte_valid_out <= 1'b0;
      tx_end_out <= 1'b0;
      rx_take_out <= 1'b0;
      aborted_out <= 1'b0;
      if (stat_req_in) stat_pend <= 1'b1;
      if (clk_rise) begin
        // link answers to nxt reach us two link cycles later
        nxt_p <= nxt;
        case (state)
          ST_PWRUP: begin
            state <= ST_TURN_DN;
            mode_out <= ulb_pkg::MODE_SYNC;
          end
          ST_IDLE: begin
            nxt <= 1'b0;
            dir <= 1'b0;
            if (suspend_in) begin
              state <= ST_LOWPWR;
              dir <= 1'b1;
              mode_out <= mode_in;
            end else if (data_q != ulb_pkg::IDLE_BYTE) begin
              state <= ST_TXRX;
              nxt <= 1'b1;
              rd_pend <= (data_q[7:6] == ulb_pkg::CMD_REG_RD);
              tx_byte_out <= data_q;
              tx_byte_valid_out <= 1'b1;
            end else if (rx_valid_in || stat_pend) begin
              state <= ST_TURN_UP;
              dir <= 1'b1;
            end
          end
          ST_TXRX: begin
            if (stp_q) begin
              nxt <= 1'b0;
              tx_end_out <= 1'b1;
              state <= ST_IDLE;
            end else if (rd_pend) begin
              nxt <= 1'b0;
              dir <= 1'b1;
              state <= ST_TURN_UP;
            end else if (nxt_p) begin
              tx_byte_out <= data_q;
              tx_byte_valid_out <= 1'b1;
            end
          end
          ST_TURN_UP: begin
            if (stp_q) begin
              dir <= 1'b0;
              aborted_out <= 1'b1;
              state <= ST_TURN_DN;
            end else if (rd_pend) begin
              state <= ST_RDATA;
              dout <= reg_rd_in;
              doe <= 1'b1;
            end else if (rx_valid_in) begin
              state <= ST_RX;
              nxt <= 1'b1;
              rx_take_out <= 1'b1;
              dout <= rx_data_in;
              doe <= 1'b1;
              rx_done <= rx_last_in;
            end else begin
              state <= ST_STAT;
              dout <= stat_in;
              doe <= 1'b1;
            end
          end
          ST_RX: begin
            if (stp_q || rx_done || !rx_valid_in) begin
              nxt <= 1'b0;
              dir <= 1'b0;
              doe <= 1'b0;
              aborted_out <= stp_q;
              state <= ST_TURN_DN;
            end else begin
              nxt <= 1'b1;
              rx_take_out <= 1'b1;
              dout <= rx_data_in;
              rx_done <= rx_last_in;
            end
          end
          ST_RDATA: begin
            rd_pend <= 1'b0;
            nxt <= 1'b0;
            dir <= 1'b0;
            doe <= 1'b0;
            state <= ST_TURN_DN;
          end
          ST_STAT: begin
            stat_pend <= stat_req_in;
            nxt <= 1'b0;
            dir <= 1'b0;
            doe <= 1'b0;
            state <= ST_TURN_DN;
          end
          ST_TURN_DN: begin
            dir <= 1'b0;
            state <= ST_IDLE;
          end
          ST_LOWPWR: begin
            if (stp_q) begin
              mode_out <= ulb_pkg::MODE_SYNC;
              dir <= 1'b0;
              doe <= 1'b0;
              state <= ST_TURN_DN;
            end else begin
              doe <= 1'b1;
              dout <= (mode_out == ulb_pkg::MODE_LOWPOWER) ? ulb_pkg::LOWPOWER_OUT
                : (serial_tx_in & ulb_pkg::SERIAL_OUT_MASK);
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign bus.dir = dir;
  assign bus.nxt = nxt;
  assign bus.dir_oe = ~cs_n;
  assign bus.nxt_oe = ~cs_n;
  assign bus.phy_data = dout;
  assign bus.phy_data_oe = doe & ~cs_n;
  logic unused;
  assign unused = cs_r[0] ^ cs_s[0];
endmodule

// *** verilog/ulb_pkg.sv ***
/*
  Shared constants for both ends of the ULPI-style synchronous bus.
  Assumes both ends run on one system clock and the link clock is sampled.
*/
// Notes on behaviour
// - phy keeps direction low by default
// - direction high only for rx, status, reads, power-up, reset, suspend
// - direction high during power-up, reset, suspend
// - chip select high floats direction and next
// - link stops every transmit and register write
// - stop during direction high drops direction next
// - stop ignored while chip deselected
// - next low default; requests link bytes
// - next high marks valid phy data byte
// - next low for read data, status byte
// - phy makes interface clock, bus synchronous
// - link selects at most one mode
// - phy starts in synchronous mode
// - link acts on interface clock edges
// - link idles zero, starts with nonzero command
// - one turnaround cycle per direction change
// - next high data, next low status
// - read data with direction high, next low
// - other modes use fixed line directions
// - link stop high one cycle after last byte
// - link sends reset command after clock start
// - stop held high wakes phy to sync
package ulb_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned LINK_CLK_DIV = 4;
  localparam logic [7:0] IDLE_BYTE = 8'h00;
  localparam logic [1:0] CMD_TX = 2'h1;
  localparam logic [1:0] CMD_REG_WR = 2'h2;
  localparam logic [1:0] CMD_REG_RD = 2'h3;
  localparam logic [7:0] RESET_CMD = 8'h84;
  localparam logic [7:0] LOWPOWER_OUT = 8'h00;
  localparam logic [2:0] MODE_SYNC = 3'h0;
  localparam logic [2:0] MODE_LOWPOWER = 3'h1;
  localparam logic [2:0] MODE_SERIAL6 = 3'h2;
  localparam logic [2:0] MODE_SERIAL3 = 3'h4;
  localparam logic [7:0] SERIAL_OUT_MASK = 8'hf8;
endpackage

// *** verilog/ulb_bus_if.sv ***
/*
  Bus wires between the phy end and the link end.
  Assumes the bench resolves the data lines from the two enables.
*/
`timescale 1ns/10ps
interface ulb_bus_if;
  logic link_clk;
  logic dir;
  logic dir_oe;
  logic nxt;
  logic nxt_oe;
  logic stp;
  logic [7:0] phy_data;
  logic phy_data_oe;
  logic [7:0] link_data;
  logic link_data_oe;
  logic [7:0] data;
  logic chip_sel_n;
  modport phy (output link_clk, output dir, output dir_oe, output nxt, output nxt_oe,
    input stp, output phy_data, output phy_data_oe, input data, input chip_sel_n);
  modport link (input link_clk, input dir, input nxt, output stp, output link_data,
    output link_data_oe, input data, output chip_sel_n);
endinterface

// *** verilog/ulb_edge_sync.sv ***
/*
  Two-flop synchroniser with rise detect for bus inputs.
  Assumes input is from another clock domain.
*/
`timescale 1ns/10ps
module ulb_edge_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= '0;
      sync_out <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
      prev <= sync_out;
    end
  end
  assign rise_out = sync_out & ~prev;
endmodule

// *** verilog/ulb_link_end.sv ***
/*
  Link end: sends commands and bytes, releases the bus on direction high.
  Assumes phy makes the interface clock, sampled here through two flops.
*/
`timescale 1ns/10ps
module ulb_link_end (
  input wire logic clk_in,
  input wire logic rst_in,
  ulb_bus_if.link bus,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic wake_in,
  output logic tx_ready_out,
  output logic [7:0] rx_byte_out,
  output logic rx_data_out,
  output logic rx_stat_out,
  output logic init_done_out
);
  typedef enum {LS_RESET, LS_IDLE, LS_SEND, LS_STOP, LS_WAIT} ulb_link_e;
  ulb_link_e state;
  logic [2:0] s;
  logic [2:0] r;
  logic dir_q;
  logic turn;
  logic [7:0] dq;
  logic [7:0] dq1;
  logic [7:0] dout;
  logic doe;
  logic stp;
  logic pend_last;
  logic rd_cmd;

  ulb_edge_sync #(.W(3)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({bus.link_clk, bus.dir, bus.nxt}),
    .sync_out(s),
    .rise_out(r)
  );
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dq1 <= ulb_pkg::IDLE_BYTE;
      dq <= ulb_pkg::IDLE_BYTE;
    end else begin
      dq1 <= bus.data;
      dq <= dq1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive side, turnaround skipped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dir_q <= 1'b1;
      turn <= 1'b0;
      rx_byte_out <= ulb_pkg::IDLE_BYTE;
      rx_data_out <= 1'b0;
      rx_stat_out <= 1'b0;
    end else begin
      rx_data_out <= 1'b0;
      rx_stat_out <= 1'b0;
      if (r[2]) begin
        dir_q <= s[1];
        turn <= s[1] != dir_q;
        if (s[1] && dir_q) begin
          rx_byte_out <= dq;
          rx_data_out <= s[0];
          rx_stat_out <= ~s[0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= LS_RESET;
      dout <= ulb_pkg::IDLE_BYTE;
      doe <= 1'b0;
      stp <= 1'b0;
      tx_ready_out <= 1'b0;
      init_done_out <= 1'b0;
      pend_last <= 1'b0;
      rd_cmd <= 1'b0;
    end else begin
      tx_ready_out <= 1'b0;
      if (r[2]) begin
        doe <= ~s[1] & ~(turn | (s[1] != dir_q));
        stp <= 1'b0;
        case (state)
          LS_RESET: begin
            if (!s[1] && !turn) begin
              dout <= ulb_pkg::RESET_CMD;
              state <= LS_SEND;
              pend_last <= 1'b1;
            end
          end
          LS_IDLE: begin
            dout <= ulb_pkg::IDLE_BYTE;
            if (wake_in) begin
              stp <= 1'b1;
            end else if (tx_valid_in && tx_data_in != ulb_pkg::IDLE_BYTE && !s[1] && !turn) begin
              dout <= tx_data_in;
              tx_ready_out <= 1'b1;
              pend_last <= tx_last_in;
              rd_cmd <= (tx_data_in[7:6] == ulb_pkg::CMD_REG_RD);
              state <= LS_SEND;
            end
          end
          LS_SEND: begin
            if (s[1]) begin
              state <= LS_WAIT;
            end else if (s[0]) begin
              if (pend_last) begin
                dout <= ulb_pkg::IDLE_BYTE;
                // a read command is answered by turnaround, not stopped
                if (rd_cmd) begin
                  state <= LS_WAIT;
                end else begin
                  stp <= 1'b1;
                  state <= LS_STOP;
                end
              end else if (tx_valid_in) begin
                dout <= tx_data_in;
                tx_ready_out <= 1'b1;
                pend_last <= tx_last_in;
              end
            end
          end
          LS_STOP: begin
            init_done_out <= 1'b1;
            state <= LS_IDLE;
          end
          LS_WAIT: begin
            dout <= ulb_pkg::IDLE_BYTE;
            if (!s[1]) state <= LS_IDLE;
          end
          default: state <= LS_IDLE;
        endcase
      end
    end
  end

  assign bus.link_data = dout;
  assign bus.link_data_oe = doe;
  assign bus.stp = stp;
  assign bus.chip_sel_n = 1'b0;
endmodule

// *** testbench/ulb_bus_checker.sv ***
/*
  Protocol assertions on the wires between the phy end and the link end.
  Assumes one clk_in domain and a link clock divided by four from it.
*/
`timescale 1ns/10ps
module ulb_bus_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_clk,
  input wire logic dir,
  input wire logic dir_oe,
  input wire logic nxt,
  input wire logic nxt_oe,
  input wire logic stp,
  input wire logic phy_data_oe,
  input wire logic link_data_oe,
  input wire logic chip_sel_n
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////
  property p_dir_reset;
    $fell(rst_in) |-> dir;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir low at reset release");
  property p_clk_div;
    $rose(link_clk) |=> (!$rose(link_clk))[*3] ##1 $rose(link_clk);
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("link clock period wrong");
  property p_abort;
    $rose(link_clk) && stp && dir && !chip_sel_n |-> ##[1:16] !dir;
  endproperty
  a_abort: assert property (p_abort) else $error("dir held after stop");
  property p_stp_width;
    $rose(stp) && !dir |-> stp [*4] ##1 !stp;
  endproperty
  a_stp_width: assert property (p_stp_width) else $error("stop not one link cycle");
  property p_phy_quiet;
    (!dir) [*5] |-> !phy_data_oe;
  endproperty
  a_phy_quiet: assert property (p_phy_quiet) else $error("phy drives with dir low");
  property p_link_release;
    dir [*8] |-> !link_data_oe;
  endproperty
  a_link_release: assert property (p_link_release) else $error("link drives with dir high");
  property p_no_fight;
    !(phy_data_oe && link_data_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive data");
  property p_nxt_tx;
    nxt && !dir |-> link_data_oe;
  endproperty
  a_nxt_tx: assert property (p_nxt_tx) else $error("nxt while link idle");
  property p_turn;
    $rose(dir) |-> !nxt;
  endproperty
  a_turn: assert property (p_turn) else $error("nxt in turnaround");
  property p_rx_data;
    dir && nxt |-> phy_data_oe;
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx byte not driven");
  property p_cs_float;
    chip_sel_n [*4] |-> !dir_oe && !nxt_oe;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("outputs driven deselected");
  c_tx: cover property (nxt && !dir);
  c_rx: cover property (dir && nxt);
  c_stp_dir: cover property (stp && dir);
endmodule

// *** testbench/test_ulpi_phy_sync_bus_control.sv ***
/*
  Bench joining the phy end and the link end over one bus interface.
  Assumes the bench resolves the data lines, with pull-downs when idle.
*/
`timescale 1ns/10ps
module test_ulpi_phy_sync_bus_control;
  typedef struct packed {logic [1:0] kind; logic [1:0] n; logic [23:0] b;} ulb_row_s;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic suspend_in = 1'b0, rx_valid_in = 1'b0, rx_last_in = 1'b0, stat_req_in = 1'b0;
  logic [7:0] rx_data_in = 8'h00, stat_in = 8'h00, reg_rd_in = 8'h00, serial_tx_in = 8'hb6;
  logic [2:0] mode_in = 3'h0;
  logic tx_valid_in = 1'b0, tx_last_in = 1'b0, wake_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00;
  logic rx_take_out, tx_byte_valid_out, tx_end_out, aborted_out;
  logic tx_ready_out, rx_data_out, rx_stat_out, init_done_out;
  logic [7:0] tx_byte_out, rx_byte_out, msk;
  logic [2:0] mode_out;
  logic [2:0] modes [3] = '{ulb_pkg::MODE_LOWPOWER, ulb_pkg::MODE_SERIAL6, ulb_pkg::MODE_SERIAL3};
  int n_errors = 0, num_checks = 0, n_end = 0, want = 0;
  logic [7:0] phy_q [$], dat_q [$], st_q [$];
  // tx, reg write, rx, rx single, reg read, status
  ulb_row_s rows [6] = '{'{2'h0, 2'h3, 24'h41a500}, '{2'h0, 2'h2, 24'h853c00}, '{2'h1, 2'h3, 24'h1122ff},
    '{2'h1, 2'h1, 24'h800000}, '{2'h2, 2'h1, 24'hc55a00}, '{2'h3, 2'h1, 24'h6b0000}};
  ulb_bus_if i_ulb_bus_if ();
  assign i_ulb_bus_if.data = i_ulb_bus_if.phy_data_oe ? i_ulb_bus_if.phy_data :
    (i_ulb_bus_if.link_data_oe ? i_ulb_bus_if.link_data : 8'h00);
  ulb_phy_end i_ulb_phy_end (.clk_in(clk_in), .rst_in(rst_in), .bus(i_ulb_bus_if), .suspend_in(suspend_in),
    .rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_last_in(rx_last_in), .stat_req_in(stat_req_in),
    .stat_in(stat_in), .reg_rd_in(reg_rd_in), .mode_in(mode_in), .serial_tx_in(serial_tx_in),
    .rx_take_out(rx_take_out), .tx_byte_out(tx_byte_out), .tx_byte_valid_out(tx_byte_valid_out),
    .tx_end_out(tx_end_out), .mode_out(mode_out), .aborted_out(aborted_out));
  ulb_link_end i_ulb_link_end (.clk_in(clk_in), .rst_in(rst_in), .bus(i_ulb_bus_if), .tx_valid_in(tx_valid_in),
    .tx_data_in(tx_data_in), .tx_last_in(tx_last_in), .wake_in(wake_in), .tx_ready_out(tx_ready_out),
    .rx_byte_out(rx_byte_out), .rx_data_out(rx_data_out), .rx_stat_out(rx_stat_out), .init_done_out(init_done_out));
  ulb_bus_checker i_ulb_bus_checker (.clk_in(clk_in), .rst_in(rst_in), .link_clk(i_ulb_bus_if.link_clk),
    .dir(i_ulb_bus_if.dir), .dir_oe(i_ulb_bus_if.dir_oe), .nxt(i_ulb_bus_if.nxt), .nxt_oe(i_ulb_bus_if.nxt_oe),
    .stp(i_ulb_bus_if.stp), .phy_data_oe(i_ulb_bus_if.phy_data_oe), .link_data_oe(i_ulb_bus_if.link_data_oe),
    .chip_sel_n(i_ulb_bus_if.chip_sel_n));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (tx_byte_valid_out === 1'b1) phy_q.push_back(tx_byte_out);
    if (rx_data_out === 1'b1) dat_q.push_back(rx_byte_out);
    if (rx_stat_out === 1'b1) st_q.push_back(rx_byte_out);
    if (tx_end_out === 1'b1) n_end++;
  end
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic cond(input int w);
    case (w)
      0: return tx_ready_out === 1'b1;
      1: return init_done_out === 1'b1 && i_ulb_bus_if.dir === 1'b0;
      2: return rx_take_out === 1'b1;
      3: return phy_q.size() >= want && n_end > 0;
      4: return dat_q.size() >= want;
      5: return st_q.size() > 0;
      7: return aborted_out === 1'b1;
      default: return mode_out === want[2:0];
    endcase
  endfunction
  task automatic wait_on(input int w);
    int k;
    k = 0;
    while (!cond(w) && k < 400) begin
      tick();
      k++;
    end
    if (!cond(w)) begin
      n_errors++;
      $display("unexpected wait %0d: expected done seen timeout", w);
      final_report();
    end
  endtask
  task automatic put(input logic [7:0] d, input logic last);
    tx_valid_in = 1'b1;
    tx_data_in = d;
    tx_last_in = last;
    tick();
    wait_on(0);
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (10) tick();
    check1("dir in reset", 1'b1, i_ulb_bus_if.dir);
    check1("nxt in reset", 1'b0, i_ulb_bus_if.nxt);
    rst_in = 1'b0;
    wait_on(1);
    check8("mode after reset", {5'h00, ulb_pkg::MODE_SYNC}, {5'h00, mode_out});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    foreach (rows[r]) begin
      phy_q.delete();
      dat_q.delete();
      st_q.delete();
      n_end = 0;
      want = int'(rows[r].n);
      case (rows[r].kind)
        2'h0: begin
          for (int i = 0; i < want; i++) put(rows[r].b[23-8*i -: 8], i == want - 1);
          tx_valid_in = 1'b0;
          wait_on(3);
          for (int i = 0; i < want; i++) check8("phy byte", rows[r].b[23-8*i -: 8], phy_q[i]);
          check8("stop count", 8'h01, 8'(n_end));
        end
        2'h1: begin
          for (int i = 0; i < want; i++) begin
            rx_valid_in = 1'b1;
            rx_data_in = rows[r].b[23-8*i -: 8];
            rx_last_in = (i == want - 1);
            tick();
            wait_on(2);
          end
          rx_valid_in = 1'b0;
          wait_on(4);
          for (int i = 0; i < want; i++) check8("rx byte", rows[r].b[23-8*i -: 8], dat_q[i]);
        end
        2'h2: begin
          reg_rd_in = rows[r].b[15:8];
          put(rows[r].b[23:16], 1'b1);
          tx_valid_in = 1'b0;
          wait_on(5);
          check8("read data", rows[r].b[15:8], st_q[0]);
        end
        default: begin
          stat_in = rows[r].b[23:16];
          stat_req_in = 1'b1;
          tick();
          stat_req_in = 1'b0;
          wait_on(5);
          check8("status byte", rows[r].b[23:16], st_q[0]);
        end
      endcase
      wait_on(1);
    end
    // suspend in each mode, then wake through stop
    foreach (modes[m]) begin
      mode_in = modes[m];
      suspend_in = 1'b1;
      want = int'(modes[m]);
      wait_on(6);
      repeat (8) tick();
      msk = (modes[m] == ulb_pkg::MODE_LOWPOWER) ? 8'hff : ulb_pkg::SERIAL_OUT_MASK;
      check1("dir in suspend", 1'b1, i_ulb_bus_if.dir);
      check8("mode lines", ((modes[m] == ulb_pkg::MODE_LOWPOWER) ? ulb_pkg::LOWPOWER_OUT : serial_tx_in) & msk,
        i_ulb_bus_if.phy_data & msk);
      suspend_in = 1'b0;
      wake_in = 1'b1;
      want = int'(ulb_pkg::MODE_SYNC);
      wait_on(6);
      wake_in = 1'b0;
      check8("mode after wake", {5'h00, ulb_pkg::MODE_SYNC}, {5'h00, mode_out});
      wait_on(1);
    end
    // stop while receiving aborts the phy
    rx_valid_in = 1'b1;
    rx_data_in = 8'h3d;
    rx_last_in = 1'b0;
    wait_on(2);
    wake_in = 1'b1;
    wait_on(7);
    check1("aborted", 1'b1, aborted_out);
    rx_valid_in = 1'b0;
    wake_in = 1'b0;
    wait_on(1);
    check1("dir after abort", 1'b0, i_ulb_bus_if.dir);
    do_reset();
    final_report();
  end
endmodule
